// ---- core/frc_pkg.sv ----
// frequency reference conditioner: shared constants, config and result types
// assumes one 250 MHz system clock; voltage words are signed millivolts
package frc_pkg;
  // ==========================================================
  // timing
  localparam int CLK_NS = 4;
  localparam int FILT_TICK_NS = 1000000; // filter updates once per ms
  localparam int TICK_CYC = FILT_TICK_NS / CLK_NS;
  localparam int FILT_FRAC = 16;
  // ==========================================================
  // source selector codes
  localparam logic [3:0] SRC_KEY_DIRECT = 4'h0;
  localparam logic [3:0] SRC_KEY_UPDN = 4'h1;
  localparam logic [3:0] SRC_VOLT_ONE = 4'h2;
  localparam logic [3:0] SRC_CURR_ONE = 4'h3;
  localparam logic [3:0] SRC_VOLT_TWO = 4'h4;
  localparam logic [3:0] SRC_CURR_TWO = 4'h5;
  localparam logic [3:0] SRC_SERIAL = 4'h6;
  localparam logic [3:0] SRC_ENCODER = 4'h7;
  localparam logic [3:0] SRC_FIELDBUS = 4'h8;
  localparam logic [3:0] SRC_PLC = 4'h9;
  // ==========================================================
  // key bit positions
  localparam int KEY_PROGRAM_KEY = 0;
  localparam int KEY_ESC = 1;
  localparam int KEY_UP = 2;
  localparam int KEY_DOWN = 3;
  // ==========================================================
  // scales and limits
  localparam logic [15:0] VFULL_MV = 16'h2710; // 10 V
  localparam logic [31:0] PCT_FULL = 32'h0000_2710; // 100.00 %
  localparam logic [31:0] PCT_CAP = 32'h0000_4E20; // 200.00 %
  localparam logic [15:0] QSTEP_MIN = 16'h0004; // 0.04 %
  localparam logic [15:0] KEY_STEP = 16'h0001; // 0.01 Hz per press
  localparam logic POL_UNIPOLAR = 1'h0;
  // ==========================================================
  // configuration carrier
  typedef struct packed {
    logic [3:0] src;
    logic bipolar;
    logic invert;
    logic [13:0] filt_ms;
    logic [9:0] qstep;
    logic [15:0] full_hz;
    logic [15:0] max_hz;
    logic signed [15:0] px1;
    logic signed [15:0] py1;
    logic signed [15:0] px2;
    logic signed [15:0] py2;
    logic signed [15:0] nx1;
    logic signed [15:0] ny1;
    logic signed [15:0] nx2;
    logic signed [15:0] ny2;
  } frc_cfg_s;
  // reset configuration; max_hz is a plain choice
  localparam frc_cfg_s CFG_RST = '{
    src: SRC_KEY_DIRECT, bipolar: POL_UNIPOLAR, invert: 1'h0,
    filt_ms: 14'h000A, qstep: 10'h004, full_hz: 16'h1770, max_hz: 16'h1770,
    px1: 16'sh0000, py1: 16'sh0000, px2: 16'sh2710, py2: 16'sh2710,
    nx1: 16'sh0000, ny1: 16'sh0000, nx2: -16'sh2710, ny2: -16'sh2710};
  // result carrier
  typedef struct packed {
    logic [15:0] freq;
    logic rev;
  } frc_ref_s;
endpackage

// ---- core/frc_top.sv ----
// frequency reference conditioner: source select, keypad entry, analog path
// assumes volt_in comes from a same-clock converter; key pins and entry word are asynchronous
`timescale 1ns/1ps

// Behaviour
// - ten-code selector picks the reference source
// - direct mode stores entry on program key
// - up/down live edit, program stores, escape discards
// - unipolar or bipolar input, sign gives direction
// - polarity setting, unipolar by default
// - full-scale frequency equals 100 percent
// - two-point line maps voltage to percent
// - monitor reports present input voltage
// - first-order low-pass with settable time constant
// - inversion flips the derived direction
// - quantize in percent-of-full-scale steps
// - hysteresis, fall steps after quarter step
// - negative side uses its own line
// - run direction combines with input sign
module frc_top
  import frc_pkg::*;
#(
  parameter int TICK_CYCLES = frc_pkg::TICK_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // configuration
  input wire logic cfg_wr,
  input wire frc_pkg::frc_cfg_s cfg_in,
  // analog and run inputs
  input wire logic signed [15:0] volt_in,
  input wire logic run_rev,
  // keypad
  input wire logic [3:0] key_pins,
  input wire logic [15:0] keypad_entry,
  // results
  output frc_pkg::frc_ref_s freq_ref,
  output logic [15:0] input_voltage_monitor,
  output logic [15:0] cmd_freq,
  output logic nv_wr,
  output logic live_edit
);
  import frc_pkg::*;

  // ==========================================================
  // helpers
  function automatic logic [15:0] frc_qfloor(input logic [16:0] a, input logic [15:0] q);
    return 16'((a / 17'(q)) * 17'(q));
  endfunction

  function automatic logic signed [31:0] frc_lin(input logic signed [15:0] v, input logic signed [15:0] x1,
    input logic signed [15:0] y1, input logic signed [15:0] x2, input logic signed [15:0] y2);
    logic signed [31:0] dx;
    dx = 32'(x2) - 32'(x1);
    if (dx == 32'sh0) begin
      return 32'(y1);
    end
    return 32'(y1) + ((32'(v) - 32'(x1)) * (32'(y2) - 32'(y1))) / dx;
  endfunction

  function automatic logic [15:0] frc_clamp(input logic [31:0] a, input logic [15:0] mx);
    return (a > 32'(mx)) ? mx : a[15:0];
  endfunction

  // ==========================================================
  // key synchroniser; the second and third stages feed the edge detect
  // entry word must be steady before the program key; the key event and ent2_ff arrive after the same two stages
  logic [3:0] ks1_ff, ks2_ff, ks3_ff;
  logic [3:0] key_ev;
  logic [15:0] ent1_ff, ent2_ff;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ks1_ff <= 4'h0;
      ks2_ff <= 4'h0;
      ks3_ff <= 4'h0;
      ent1_ff <= 16'h0;
      ent2_ff <= 16'h0;
    end else begin
      ks1_ff <= key_pins;
      ks2_ff <= ks1_ff;
      ks3_ff <= ks2_ff;
      ent1_ff <= keypad_entry;
      ent2_ff <= ent1_ff;
    end
  end
  assign key_ev = ks2_ff & ~ks3_ff;

  // ==========================================================
  // configuration register, loads as one word
  frc_cfg_s cfg_ff, nxt_cfg;
  always_comb begin
    nxt_cfg = cfg_wr ? cfg_in : cfg_ff;
  end
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cfg_ff <= CFG_RST;
    end else begin
      cfg_ff <= nxt_cfg;
    end
  end

  // ==========================================================
  // low-pass filter, one update per ms tick
  logic [17:0] tick_ff, nxt_tick;
  logic tick;
  logic signed [33:0] filt_ff, nxt_filt, fx, fdiff;
  logic signed [15:0] v_filt;
  assign tick = (tick_ff == 18'(TICK_CYCLES - 1));
  assign fx = 34'(volt_in) <<< FILT_FRAC;
  assign fdiff = fx - filt_ff;
  assign v_filt = filt_ff[FILT_FRAC +: 16];
  always_comb begin
    nxt_tick = tick ? 18'h0 : tick_ff + 18'h1;
    nxt_filt = filt_ff;
    if (tick) begin
      // step of diff/(T+1) per ms reaches ~63 % after T ms
      if (cfg_ff.filt_ms == 14'h0) begin
        nxt_filt = fx;
      end else begin
        nxt_filt = filt_ff + fdiff / $signed({20'h0, cfg_ff.filt_ms} + 34'h1);
      end
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      tick_ff <= 18'h0;
      filt_ff <= 34'sh0;
    end else begin
      tick_ff <= nxt_tick;
      filt_ff <= nxt_filt;
    end
  end

  // ==========================================================
  // polarity and magnitude
  logic neg;
  logic [15:0] mag, q, qq;
  always_comb begin
    neg = cfg_ff.bipolar && (v_filt < 16'sh0);
    if (!cfg_ff.bipolar && v_filt < 16'sh0) begin
      mag = 16'h0; // unipolar ignores negative input
    end else begin
      mag = neg ? 16'(-v_filt) : 16'(v_filt);
    end
    if (mag > VFULL_MV) begin
      mag = VFULL_MV;
    end
    // step in mV equals setting in 0.01 % of 10 V
    q = (16'(cfg_ff.qstep) < QSTEP_MIN) ? QSTEP_MIN : 16'(cfg_ff.qstep);
    qq = q >> 2;
  end

  // ==========================================================
  // quantiser with hysteresis: rise on a whole step, fall on a quarter
  logic [15:0] lvl_ff, nxt_lvl;
  logic fall_ok;
  assign fall_ok = ({1'b0, mag} + {1'b0, qq}) < {1'b0, lvl_ff};
  always_comb begin
    nxt_lvl = lvl_ff;
    if ({1'b0, mag} >= {1'b0, lvl_ff} + {1'b0, q}) begin
      nxt_lvl = frc_qfloor({1'b0, mag}, q);
    end else if (fall_ok) begin
      nxt_lvl = frc_qfloor({1'b0, mag} + {1'b0, qq}, q);
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      lvl_ff <= 16'h0;
    end else begin
      lvl_ff <= nxt_lvl;
    end
  end

  // ==========================================================
  // two-point scaling to percent and frequency
  logic signed [31:0] pct;
  logic [31:0] pct_u;
  logic [15:0] ana_freq;
  logic ana_rev;
  always_comb begin
    if (neg) begin
      pct = -frc_lin(-$signed(lvl_ff), cfg_ff.nx1, cfg_ff.ny1, cfg_ff.nx2, cfg_ff.ny2);
    end else begin
      pct = frc_lin($signed(lvl_ff), cfg_ff.px1, cfg_ff.py1, cfg_ff.px2, cfg_ff.py2);
    end
    // cap keeps the product below 2^31
    if (pct < 32'sh0) begin
      pct_u = 32'h0;
    end else if (pct > $signed(PCT_CAP)) begin
      pct_u = PCT_CAP;
    end else begin
      pct_u = pct;
    end
    ana_freq = frc_clamp(pct_u * 32'(cfg_ff.full_hz) / PCT_FULL, cfg_ff.max_hz);
    ana_rev = neg ^ cfg_ff.invert ^ run_rev;
  end

  // ==========================================================
  // keypad entry
  typedef enum logic {FRC_KP_IDLE, FRC_KP_LIVE} frc_kp_e;
  frc_kp_e kp_ff, nxt_kp;
  logic [15:0] cmd_ff, nxt_cmd, live_ff, nxt_live;
  logic nv_ff, nxt_nv;
  logic edit_ff, nxt_edit;
  logic updn;
  assign updn = (cfg_ff.src == SRC_KEY_UPDN);
  always_comb begin
    nxt_kp = kp_ff;
    nxt_cmd = cmd_ff;
    nxt_live = live_ff;
    nxt_nv = 1'b0;
    unique case (kp_ff)
      FRC_KP_IDLE: begin
        if (key_ev[KEY_PROGRAM_KEY] && cfg_ff.src == SRC_KEY_DIRECT) begin
          nxt_cmd = frc_clamp(32'(ent2_ff), cfg_ff.max_hz);
          nxt_nv = 1'b1;
        end else if (key_ev[KEY_PROGRAM_KEY] && updn) begin
          nxt_kp = FRC_KP_LIVE;
          nxt_live = cmd_ff;
        end
      end
      FRC_KP_LIVE: begin
        if (!updn) begin
          nxt_kp = FRC_KP_IDLE; // source changed mid-edit: drop it
        end else if (key_ev[KEY_PROGRAM_KEY]) begin
          nxt_cmd = live_ff;
          nxt_nv = 1'b1;
          nxt_kp = FRC_KP_IDLE;
        end else if (key_ev[KEY_ESC]) begin
          nxt_live = cmd_ff;
          nxt_kp = FRC_KP_IDLE;
        end else if (key_ev[KEY_UP]) begin
          nxt_live = frc_clamp(32'(live_ff) + 32'(KEY_STEP), cfg_ff.max_hz);
        end else if (key_ev[KEY_DOWN]) begin
          nxt_live = (live_ff > KEY_STEP) ? live_ff - KEY_STEP : 16'h0;
        end
      end
    endcase
    nxt_edit = (nxt_kp == FRC_KP_LIVE);
  end
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      kp_ff <= FRC_KP_IDLE;
      cmd_ff <= 16'h0;
      live_ff <= 16'h0;
      nv_ff <= 1'b0;
      edit_ff <= 1'b0;
    end else begin
      kp_ff <= nxt_kp;
      cmd_ff <= nxt_cmd;
      live_ff <= nxt_live;
      nv_ff <= nxt_nv;
      edit_ff <= nxt_edit;
    end
  end

  // ==========================================================
  // source select and output registers
  frc_ref_s ref_ff, nxt_ref;
  logic [15:0] mon_ff, nxt_mon;
  logic [15:0] vabs;
  always_comb begin
    nxt_ref.rev = run_rev;
    // sources without a path here report zero
    unique case (cfg_ff.src)
      SRC_KEY_DIRECT: nxt_ref.freq = frc_clamp(32'(cmd_ff), cfg_ff.max_hz);
      SRC_KEY_UPDN: nxt_ref.freq = frc_clamp(32'(kp_ff == FRC_KP_LIVE ? live_ff : cmd_ff), cfg_ff.max_hz);
      SRC_VOLT_ONE: begin
        nxt_ref.freq = ana_freq;
        nxt_ref.rev = ana_rev;
      end
      default: nxt_ref.freq = 16'h0;
    endcase
    vabs = (volt_in < 16'sh0) ? 16'(-volt_in) : 16'(volt_in);
    nxt_mon = (vabs > VFULL_MV) ? VFULL_MV : vabs;
  end
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ref_ff <= '0;
      mon_ff <= 16'h0;
    end else begin
      ref_ff <= nxt_ref;
      mon_ff <= nxt_mon;
    end
  end

  assign freq_ref = ref_ff;
  assign input_voltage_monitor = mon_ff;
  assign cmd_freq = cmd_ff;
  assign nv_wr = nv_ff;
  assign live_edit = edit_ff; // registered copy of the live state

  // ==========================================================
  // checks
  logic uni_fwd;
  assign uni_fwd = (cfg_ff.src == SRC_VOLT_ONE) && !cfg_ff.bipolar && !cfg_ff.invert && !run_rev;

  nv_store_a: assert property (@(posedge clk) disable iff (!rst_b)
    nv_wr |-> $past(key_ev[KEY_PROGRAM_KEY])) else $error("store without program key");

  esc_keep_a: assert property (@(posedge clk) disable iff (!rst_b)
    (live_edit && updn && !key_ev[KEY_PROGRAM_KEY] && key_ev[KEY_ESC]) |=> (!nv_wr && cmd_freq == $past(cmd_freq)
    && !live_edit)) else $error("escape changed stored frequency");

  live_up_a: assert property (@(posedge clk) disable iff (!rst_b)
    (live_edit && updn && key_ev == 4'h4 && live_ff < cfg_ff.max_hz) |=> live_ff == $past(live_ff) + KEY_STEP)
    else $error("up key did not raise live frequency");

  clamp_max_a: assert property (@(posedge clk) disable iff (!rst_b)
    $stable(cfg_ff) |-> freq_ref.freq <= cfg_ff.max_hz) else $error("target above maximum");

  uni_dir_a: assert property (@(posedge clk) disable iff (!rst_b)
    $past(uni_fwd) |-> !freq_ref.rev) else $error("unipolar input reversed direction");

  fall_quarter_a: assert property (@(posedge clk) disable iff (!rst_b)
    (lvl_ff < $past(lvl_ff)) |-> $past(fall_ok)) else $error("level fell inside hysteresis band");

  filt_pass_a: assert property (@(posedge clk) disable iff (!rst_b)
    (tick && cfg_ff.filt_ms == 14'h0) |=> v_filt == $past(volt_in)) else $error("zero time constant lagged");

  mon_range_a: assert property (@(posedge clk) disable iff (!rst_b)
    ##1 input_voltage_monitor <= VFULL_MV) else $error("monitor out of range");

endmodule // frc_top

// ---- testbench/frc_partner.sv ----
// keypad operator and analog source model for the conditioner bench
// assumes the bench calls these tasks; stimulus moves at falling edges
`timescale 1ns/1ps
module frc_partner (
  // clock
  input wire logic clk,
  // keypad and analog stimulus
  output logic [3:0] key_pins,
  output logic [15:0] keypad_entry,
  output logic signed [15:0] volt_in
);
  initial begin
    key_pins = 4'h0;
    keypad_entry = 16'h0000;
    volt_in = 16'sh0000;
  end
  // ==========================================================
  // one stroke; low gap keeps each stroke a single key event
  task automatic press(input int k, input logic [15:0] e);
    @(negedge clk);
    keypad_entry = e;
    key_pins[k] = 1'b1;
    repeat (4) @(negedge clk);
    key_pins[k] = 1'b0;
    repeat (3) @(negedge clk);
  endtask
  // analog level step
  task automatic drive(input logic signed [15:0] v);
    @(negedge clk);
    volt_in = v;
  endtask
endmodule // frc_partner

// ---- testbench/frc_top_tb.sv ----
// self-checking bench for the frequency reference conditioner
// assumes frc_partner plays keypad and source; short filter tick
`timescale 1ns/1ps
module frc_top_tb;
  import frc_pkg::*;
  localparam int TICKS = 10;
  logic clk, rst_b, cfg_wr, run_rev, nv_wr, live_edit;
  frc_cfg_s cfg_in, cfg;
  frc_ref_s freq_ref;
  logic [15:0] mon, cmd_freq, ent, keypad_entry;
  logic [3:0] key_pins;
  logic signed [15:0] volt_in;
  logic [15:0] exp_q[$];
  logic [31:0] tab [5];
  int errors = 0;
  int comparisons = 0;
  int cyc = 0;
  integer seed = 32'h5b8a86dd;
  frc_top #(.TICK_CYCLES(TICKS)) frc_top_inst (.clk(clk), .rst_b(rst_b), .cfg_wr(cfg_wr), .cfg_in(cfg_in),
    .volt_in(volt_in), .run_rev(run_rev), .key_pins(key_pins), .keypad_entry(keypad_entry),
    .freq_ref(freq_ref), .input_voltage_monitor(mon), .cmd_freq(cmd_freq), .nv_wr(nv_wr),
    .live_edit(live_edit));
  frc_partner frc_partner_inst (.clk(clk), .key_pins(key_pins), .keypad_entry(keypad_entry),
    .volt_in(volt_in));
  // ==========================================================
  // clock, 4 ns period
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // ==========================================================
  // compare and report
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic load(input frc_cfg_s c);
    @(negedge clk);
    cfg_wr = 1'b1;
    cfg_in = c;
    @(negedge clk);
    cfg_wr = 1'b0;
  endtask
  // several filter ticks so the zero-lag filter and pipeline settle
  task automatic settle();
    repeat (3 * TICKS) @(negedge clk);
  endtask
  task automatic complete_run();
    $display("comparisons=%0d errors=%0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // ==========================================================
  // scoreboard: each store strobe takes the oldest noted value
  always @(negedge clk) begin
    if (rst_b === 1'b1 && nv_wr !== 1'b0) begin
      if (exp_q.size() == 0)
        check(nv_wr, 1'b0);
      else
        check(cmd_freq, exp_q.pop_front());
    end
  end
  // hang guard, far above the expected run length
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      errors++;
      complete_run();
    end
  end
  // ==========================================================
  // main sequence
  initial begin
    rst_b = 1'b0;
    cfg_wr = 1'b0;
    cfg_in = CFG_RST;
    run_rev = 1'b0;
    repeat (12) @(negedge clk);
    rst_b = 1'b1;
    check(freq_ref, 17'h0);
    check({cmd_freq, nv_wr, live_edit}, 18'h0);
    $display("reset done");
    // direct entry from reset source; random value then over-range
    ent = $random(seed);
    ent = ent % 16'h1770;
    exp_q.push_back(ent);
    frc_partner_inst.press(KEY_PROGRAM_KEY, ent);
    exp_q.push_back(16'h1770);
    frc_partner_inst.press(KEY_PROGRAM_KEY, 16'hFFFF);
    check(freq_ref.freq, 16'h1770);
    $display("direct done");
    // live up/down: store on program, discard on escape
    cfg = CFG_RST;
    cfg.src = SRC_KEY_UPDN;
    load(cfg);
    frc_partner_inst.press(KEY_PROGRAM_KEY, 16'h0);
    check(live_edit, 1'b1);
    for (int i = 0; i < 4; i++) frc_partner_inst.press((i < 3) ? KEY_DOWN : KEY_UP, 16'h0);
    check(freq_ref.freq, 16'h176E);
    exp_q.push_back(16'h176E);
    frc_partner_inst.press(KEY_PROGRAM_KEY, 16'h0);
    frc_partner_inst.press(KEY_PROGRAM_KEY, 16'h0);
    frc_partner_inst.press(KEY_DOWN, 16'h0);
    frc_partner_inst.press(KEY_ESC, 16'h0);
    check({live_edit, cmd_freq}, {1'b0, 16'h176E});
    $display("updown done");
    // unipolar analog, 1 % step: rise, quarter-step fall, negative
    cfg.src = SRC_VOLT_ONE;
    cfg.filt_ms = 14'h0000;
    cfg.qstep = 10'h064;
    load(cfg);
    tab = '{32'h09F6_05DC, 32'h09B0_05DC, 32'h09A6_05A0, 32'h2710_1770, 32'hF448_0000};
    foreach (tab[i]) begin
      frc_partner_inst.drive(tab[i][31:16]);
      settle();
      check(freq_ref.freq, tab[i][15:0]);
    end
    check(mon, 16'h0BB8);
    $display("unipolar done");
    // bipolar sign, inversion and run command in every combination
    cfg.bipolar = 1'b1;
    for (int i = 0; i < 8; i++) begin
      cfg.invert = i[1];
      load(cfg);
      run_rev = i[2];
      frc_partner_inst.drive(i[0] ? 16'shEC78 : 16'sh1388);
      settle();
      check(freq_ref, {16'h0BB8, i[0] ^ i[1] ^ i[2]});
    end
    $display("bipolar done");
    // unserved sources give zero; full scale and clamp on source 2
    run_rev = 1'b0;
    cfg.invert = 1'b0;
    for (int s = 3; s < 10; s++) begin
      cfg.src = s[3:0];
      load(cfg);
      settle();
      check(freq_ref.freq, 16'h0);
    end
    cfg.src = SRC_VOLT_ONE;
    cfg.full_hz = 16'h0FA0;
    load(cfg);
    frc_partner_inst.drive(16'sh2710);
    settle();
    check(freq_ref.freq, 16'h0FA0);
    cfg.full_hz = 16'h2328;
    load(cfg);
    settle();
    check(freq_ref.freq, 16'h1770);
    $display("scale done");
    // filter: zero lag back to rest, then a step through a 10 ms time constant
    cfg.full_hz = 16'h1770;
    cfg.filt_ms = 14'h0000;
    load(cfg);
    frc_partner_inst.drive(16'sh0000);
    settle();
    check(freq_ref.freq, 16'h0);
    cfg.filt_ms = 14'h000A;
    load(cfg);
    frc_partner_inst.drive(16'sh2710);
    repeat (10 * TICKS) @(negedge clk);
    check(freq_ref.freq > 16'h0C80 && freq_ref.freq < 16'h0FA0, 1'b1);
    $display("filter done");
    check(exp_q.size(), 0);
    complete_run();
  end
endmodule // frc_top_tb
